// file: logic/rcb_core.sv
// Register bank top: system clock core plus SPI link end.
// Assumes the radio state machine pulses its events on the system clock and
// the SPI clock idles between frames; test addresses are simply ignored.
`timescale 1ns/1ps
module rcb_core
  import rcb_pkg::*;
(
  input  wire logic       sys_clk_i,          // System clock, 100 MHz
  input  wire logic       rst_n_i,            // Synchronous reset, active low
  input  wire logic       spi_clk_i,          // SPI clock from host
  input  wire logic       spi_csn_i,          // SPI chip select, active low
  input  wire logic       spi_mosi_i,         // SPI data in
  output logic            spi_miso_o,         // SPI data out
  input  wire logic       rx_ready_event_i,   // Receive data ready pulse
  input  wire logic       tx_sent_event_i,    // Transmit data sent pulse
  input  wire logic       retry_limit_event_i,// Retry limit pulse
  output logic            irq_n_o,            // Interrupt pin, active low
  output logic            crc_enable_o,       // Effective CRC enable
  output logic            crc_length_select_o,// CRC length, 1 = two bytes
  output logic            power_up_bit_o,     // Power up control
  output logic            primary_role_select_o, // 1 = primary receiver
  output logic [5:0]      auto_ack_enable_o,  // Per-pipe auto-ack enables
  output logic [5:0]      rx_pipe_enable_o,   // Per-pipe receive enables
  output logic [1:0]      address_width_field_o // Address width code
);
  import rcb_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;     // radio_control
    logic [7:0] aack;     // auto_ack_enable
    logic [7:0] rxen;     // rx_pipe_enable
    logic [7:0] awid;     // address_width_setup
    logic [2:0] evt;      // Sticky rx, tx, retry events
    logic [2:0] tsync;    // Write-pending synchroniser and edge history
    logic       irq_n;    // Registered pin
    logic       crc_en;   // Registered effective CRC enable
  } rcb_core_t;

  rcb_core_t   st_ff, nxt_st;
  rcb_xfer_if  xfer ();
  logic        wr_fire;   // One-cycle write strobe in system domain
  logic [7:0]  wdat;      // Write data, stable when strobe fires
  logic [4:0]  waddr;     // Write address, stable when strobe fires

  // Reserved-bit handling shared by all four registers
  function automatic logic [7:0] rcb_upd(input logic [7:0] d,
                                         input logic [7:0] msk,
                                         input logic [7:0] rst);
    if ((d & ~msk) != 8'h00) begin
      rcb_upd = rst;
    end else begin
      rcb_upd = d & msk;
    end
  endfunction : rcb_upd

  rcb_spi_link u_link (
    .spi_clk_i  (spi_clk_i),
    .spi_csn_i  (spi_csn_i),
    .spi_mosi_i (spi_mosi_i),
    .spi_miso_o (spi_miso_o),
    .xfer       (xfer.link)
  );

  // Words are quasi-static: sampled only after the pending level has crossed
  assign waddr   = xfer.wr_addr;
  assign wdat    = xfer.wr_data;
  assign wr_fire = st_ff.tsync[1] & ~st_ff.tsync[2];

  // Next state of the bank
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.tsync = {st_ff.tsync[1:0], xfer.wr_pend};
    if (wr_fire) begin
      case (waddr)
        RCB_OFS_CONTROL:  nxt_st.ctrl = rcb_upd(wdat, RCB_MSK_CONTROL, RCB_RST_CONTROL);
        RCB_OFS_AUTO_ACK: nxt_st.aack = rcb_upd(wdat, RCB_MSK_PIPES, RCB_RST_AUTO_ACK);
        RCB_OFS_RX_PIPE:  nxt_st.rxen = rcb_upd(wdat, RCB_MSK_PIPES, RCB_RST_RX_PIPE);
        RCB_OFS_ADDR_WID: nxt_st.awid = rcb_upd(wdat, RCB_MSK_ADDR_WID, RCB_RST_ADDR_WID);
        RCB_OFS_STATUS: begin
          // Write one clears; a same-cycle event below still wins
          nxt_st.evt = st_ff.evt & ~{wdat[RCB_BIT_EVT_RX], wdat[RCB_BIT_EVT_TX],
                                      wdat[RCB_BIT_EVT_RT]};
        end
        default: nxt_st.evt = st_ff.evt;  // Test and other addresses ignored
      endcase
    end
    nxt_st.evt = nxt_st.evt | {rx_ready_event_i, tx_sent_event_i, retry_limit_event_i};
    nxt_st.crc_en = nxt_st.ctrl[RCB_BIT_CRC_EN] | (|nxt_st.aack[5:0]);
    nxt_st.irq_n = ~((nxt_st.evt[2] & ~nxt_st.ctrl[RCB_BIT_RX_MASK]) |
                     (nxt_st.evt[1] & ~nxt_st.ctrl[RCB_BIT_TX_MASK]) |
                     (nxt_st.evt[0] & ~nxt_st.ctrl[RCB_BIT_RT_MASK]));
    if (!rst_n_i) begin
      nxt_st.ctrl   = RCB_RST_CONTROL;
      nxt_st.aack   = RCB_RST_AUTO_ACK;
      nxt_st.rxen   = RCB_RST_RX_PIPE;
      nxt_st.awid   = RCB_RST_ADDR_WID;
      nxt_st.evt    = 3'b000;
      nxt_st.irq_n  = 1'b1;
      nxt_st.crc_en = 1'b1;
    end
  end

  // Single register stage for the whole bank
  always_ff @(posedge sys_clk_i) begin
    st_ff <= nxt_st;
  end

  // Read images for the link; unused bits zero
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      xfer.rd_image[i] = 8'h00;
    end
    xfer.rd_image[RCB_OFS_CONTROL[2:0]]  = {st_ff.ctrl[7:4], st_ff.crc_en, st_ff.ctrl[2:0]};
    xfer.rd_image[RCB_OFS_AUTO_ACK[2:0]] = st_ff.aack;
    xfer.rd_image[RCB_OFS_RX_PIPE[2:0]]  = st_ff.rxen;
    xfer.rd_image[RCB_OFS_ADDR_WID[2:0]] = st_ff.awid;
    xfer.rd_image[RCB_OFS_STATUS[2:0]]   = {1'b0, st_ff.evt, 4'h0} | RCB_RST_STATUS;
  end

  assign irq_n_o               = st_ff.irq_n;
  assign crc_enable_o          = st_ff.crc_en;
  assign crc_length_select_o   = st_ff.ctrl[RCB_BIT_CRC_LEN];
  assign power_up_bit_o        = st_ff.ctrl[RCB_BIT_POWER_UP_BIT];
  assign primary_role_select_o = st_ff.ctrl[RCB_BIT_ROLE];
  assign auto_ack_enable_o     = st_ff.aack[5:0];
  assign rx_pipe_enable_o      = st_ff.rxen[5:0];
  assign address_width_field_o = st_ff.awid[1:0];

endmodule : rcb_core

// file: logic/rcb_pkg.sv
// Package for the radio configuration register bank: map offsets, field
// positions, reset values, SPI command codes and shared types.
// Assumes a 4-wire SPI link (mode 0, MSB first) and a 100 MHz system clock.
package rcb_pkg;

  // Register map offsets (5-bit map address)
  localparam logic [4:0] RCB_OFS_CONTROL   = 5'h00;  // radio_control
  localparam logic [4:0] RCB_OFS_AUTO_ACK  = 5'h01;  // auto_ack_enable
  localparam logic [4:0] RCB_OFS_RX_PIPE   = 5'h02;  // rx_pipe_enable
  localparam logic [4:0] RCB_OFS_ADDR_WID  = 5'h03;  // address_width_setup
  localparam logic [4:0] RCB_OFS_STATUS    = 5'h07;  // event status
  localparam logic [4:0] RCB_OFS_TEST_LO   = 5'h18;  // First test address
  localparam logic [4:0] RCB_OFS_TEST_HI   = 5'h1b;  // Last test address

  // Reset values
  localparam logic [7:0] RCB_RST_CONTROL   = 8'h08;
  localparam logic [7:0] RCB_RST_AUTO_ACK  = 8'h3f;
  localparam logic [7:0] RCB_RST_RX_PIPE   = 8'h03;
  localparam logic [7:0] RCB_RST_ADDR_WID  = 8'h03;
  localparam logic [7:0] RCB_RST_STATUS    = 8'h0e;  // Pipe field reads empty

  // Writable and reserved masks per register
  localparam logic [7:0] RCB_MSK_CONTROL   = 8'h7f;
  localparam logic [7:0] RCB_MSK_PIPES     = 8'h3f;
  localparam logic [7:0] RCB_MSK_ADDR_WID  = 8'h03;

  // Field positions
  localparam int RCB_BIT_RX_MASK   = 6;
  localparam int RCB_BIT_TX_MASK   = 5;
  localparam int RCB_BIT_RT_MASK   = 4;
  localparam int RCB_BIT_CRC_EN    = 3;
  localparam int RCB_BIT_CRC_LEN   = 2;
  localparam int RCB_BIT_POWER_UP_BIT    = 1;
  localparam int RCB_BIT_ROLE      = 0;
  localparam int RCB_BIT_EVT_RX    = 6;
  localparam int RCB_BIT_EVT_TX    = 5;
  localparam int RCB_BIT_EVT_RT    = 4;

  // Command decode
  localparam logic [2:0] RCB_CMD_READ      = 3'b000;
  localparam logic [2:0] RCB_CMD_WRITE     = 3'b001;

  // Link-side frame phases
  typedef enum logic [1:0] {
    RCB_PH_CMD,
    RCB_PH_DATA,
    RCB_PH_DONE
  } rcb_phase_t;

  // Address width field values
  localparam logic [1:0] RCB_AW_FIVE       = 2'b11;
  localparam logic [1:0] RCB_AW_FOUR       = 2'b10;

endpackage : rcb_pkg

// file: logic/rcb_spi_link.sv
// SPI link end: shifts command and data bytes on the SPI clock.
// Assumes SPI mode 0, chip select active low, MSB first in each byte.
// Chip select must stay low a few system clocks after the last SPI edge,
// so that the core sees the pending write before the frame logic clears.
`timescale 1ns/1ps
module rcb_spi_link
  import rcb_pkg::*;
(
  input  wire logic spi_clk_i,   // SPI clock from host
  input  wire logic spi_csn_i,   // Chip select, low in a frame
  input  wire logic spi_mosi_i,  // Serial data in
  output logic      spi_miso_o,  // Serial data out (launched falling edge)
  rcb_xfer_if.link  xfer         // Carrier to the core
);
  import rcb_pkg::*;

  // Frame state: cleared by chip select high
  typedef struct packed {
    rcb_phase_t phase;   // Frame phase
    logic [2:0] bitcnt;  // Bit within byte
    logic [7:0] shin;    // Input shifter
    logic       wpend;   // Write byte complete, held until chip select rises
  } rcb_link_t;

  // Fields that outlive the frame, so the core can still read them late
  typedef struct packed {
    logic [2:0] cmd;     // Command top bits
    logic [4:0] addr;    // Latched map address
    logic [7:0] wdata;   // Captured write byte
  } rcb_hold_t;

  rcb_link_t  st_ff, nxt_st;     // Frame state
  rcb_hold_t  hold_ff, nxt_hold; // Persistent command, address, data
  logic [7:0] tx_sh_ff;          // Output shifter, falling edge domain
  logic [7:0] shin_full;         // Byte including current bit
  logic [7:0] rd_byte;           // Byte streamed in the data phase

  // Frame logic; chip select high acts as the frame's own reset
  always_comb begin
    nxt_st        = st_ff;
    nxt_hold      = hold_ff;
    shin_full     = {st_ff.shin[6:0], spi_mosi_i};
    nxt_st.shin   = shin_full;
    nxt_st.bitcnt = st_ff.bitcnt + 3'd1;
    if (st_ff.bitcnt == 3'd7) begin
      case (st_ff.phase)
        RCB_PH_CMD: begin
          nxt_hold.cmd  = shin_full[7:5];
          nxt_hold.addr = shin_full[4:0];
          nxt_st.phase  = RCB_PH_DATA;
        end
        RCB_PH_DATA: begin
          if (hold_ff.cmd == RCB_CMD_WRITE) begin
            nxt_hold.wdata = shin_full;
            nxt_st.wpend   = 1'b1;
          end
          nxt_st.phase = RCB_PH_DONE;  // Single-byte registers only
        end
        default: nxt_st.phase = RCB_PH_DONE;
      endcase
    end
  end

  // Register image for a read; anything outside the low map reads zero
  always_comb begin
    rd_byte = 8'h00;
    if (st_ff.phase == RCB_PH_DATA && hold_ff.cmd == RCB_CMD_READ &&
        hold_ff.addr[4:3] == 2'b00) begin
      rd_byte = xfer.rd_image[hold_ff.addr[2:0]];
    end
  end

  // Frame registers; a level pending flag needs no power-up value of its own
  always_ff @(posedge spi_clk_i or posedge spi_csn_i) begin
    if (spi_csn_i) begin
      st_ff.phase  <= RCB_PH_CMD;
      st_ff.bitcnt <= 3'd0;
      st_ff.shin   <= 8'h00;
      st_ff.wpend  <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Command, address and data persist across frames for the core
  always_ff @(posedge spi_clk_i) begin
    hold_ff <= nxt_hold;
  end

  // Status streams out during the command byte, the register during data.
  // Status bit 7 always reads zero, so the cleared shifter supplies it.
  always_ff @(negedge spi_clk_i or posedge spi_csn_i) begin
    if (spi_csn_i) begin
      tx_sh_ff <= 8'h00;
    end else if (st_ff.phase == RCB_PH_CMD && st_ff.bitcnt == 3'd1) begin
      tx_sh_ff <= {xfer.rd_image[RCB_OFS_STATUS[2:0]][6:0], 1'b0};
    end else if (st_ff.bitcnt == 3'd0) begin
      tx_sh_ff <= rd_byte;
    end else begin
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
    end
  end

  assign spi_miso_o    = tx_sh_ff[7];
  assign xfer.wr_pend  = st_ff.wpend;
  assign xfer.wr_addr  = hold_ff.addr;
  assign xfer.wr_data  = hold_ff.wdata;

endmodule : rcb_spi_link

// file: logic/rcb_xfer_if.sv
// Carrier between the SPI link end and the register core.
// Write requests travel as a pending level plus stable address/data words;
// the read image travels as a stable snapshot that the link samples.
`timescale 1ns/1ps
interface rcb_xfer_if;
  logic       wr_pend;   // High from a write byte's end until chip select rises
  logic [4:0] wr_addr;   // Map address, stable until the next command byte
  logic [7:0] wr_data;   // Write data, stable until the next write byte
  logic [7:0] rd_image [0:7]; // Read images of low map (system clock)

  modport link (output wr_pend, output wr_addr, output wr_data, input rd_image);
  modport core (input wr_pend, input wr_addr, input wr_data, output rd_image);
endinterface : rcb_xfer_if

// file: tb/rcb_core_properties.sv
// Checker for the register bank: watches only the top module's ports.
// Assumes a synchronous reset held low for at least two system clocks.
`timescale 1ns/1ps
module rcb_core_properties (
  input wire logic       sys_clk_i,             // System clock
  input wire logic       rst_n_i,               // Reset, active low
  input wire logic       spi_csn_i,             // Chip select
  input wire logic       rx_ready_event_i,      // Rx ready pulse
  input wire logic       tx_sent_event_i,       // Tx sent pulse
  input wire logic       retry_limit_event_i,   // Retry limit pulse
  input wire logic       irq_n_o,               // Interrupt pin
  input wire logic       crc_enable_o,          // Effective CRC enable
  input wire logic       power_up_bit_o,        // Power up
  input wire logic       primary_role_select_o, // Role select
  input wire logic [5:0] auto_ack_enable_o,     // Auto-ack enables
  input wire logic [5:0] rx_pipe_enable_o,      // Rx pipe enables
  input wire logic [1:0] address_width_field_o  // Address width
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Eight idle clocks: any write has landed, since the update takes 3 clock edges
  sequence link_idle;
    spi_csn_i [*8];
  endsequence
  ack_reset_a : assert property ($rose(rst_n_i) |-> auto_ack_enable_o == 6'h3f)
    else $error("auto-ack enables wrong after reset");
  pipe_reset_a : assert property ($rose(rst_n_i) |-> rx_pipe_enable_o == 6'h03)
    else $error("rx pipe enables wrong after reset");
  ctrl_reset_a : assert property ($rose(rst_n_i) |->
    !power_up_bit_o && !primary_role_select_o && crc_enable_o && irq_n_o)
    else $error("control outputs wrong after reset");
  aw_reset_a : assert property ($rose(rst_n_i) |-> address_width_field_o == 2'b11)
    else $error("address width wrong after reset");
  crc_forced_a : assert property ((|auto_ack_enable_o) && $stable(auto_ack_enable_o)
    |-> crc_enable_o) else $error("crc enable not forced by auto-ack");
  irq_cause_a : assert property ($fell(irq_n_o) |->
    $past(rx_ready_event_i | tx_sent_event_i | retry_limit_event_i))
    else $error("interrupt pin fell without an event");
  irq_hold_a : assert property (link_idle ##0 !irq_n_o |=> !irq_n_o)
    else $error("interrupt pin released without a clear");
  cfg_stable_a : assert property (link_idle |=> $stable({power_up_bit_o,
    primary_role_select_o, auto_ack_enable_o, rx_pipe_enable_o, address_width_field_o}))
    else $error("configuration changed with the link idle");
endmodule : rcb_core_properties
bind rcb_core rcb_core_properties u_props (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .spi_csn_i(spi_csn_i), .rx_ready_event_i(rx_ready_event_i),
  .tx_sent_event_i(tx_sent_event_i), .retry_limit_event_i(retry_limit_event_i),
  .irq_n_o(irq_n_o), .crc_enable_o(crc_enable_o), .power_up_bit_o(power_up_bit_o),
  .primary_role_select_o(primary_role_select_o), .auto_ack_enable_o(auto_ack_enable_o),
  .rx_pipe_enable_o(rx_pipe_enable_o), .address_width_field_o(address_width_field_o));

// file: tb/rcb_host_model.sv
// Host model: one SPI frame of command byte plus one data byte.
// Assumes mode 0, MSB first; the SPI clock stands low between frames.
`timescale 1ns/1ps
module rcb_host_model (
  output logic      spi_clk_o,  // SPI clock, 80 ns period in frames
  output logic      spi_csn_o,  // Chip select, low in a frame
  output logic      spi_mosi_o, // Data to the device
  input  wire logic spi_miso_i  // Data from the device
);
  // A short select pulse at power-up gives the link a clean rising edge
  // of chip select, which is the only thing that clears its frame logic
  initial begin
    spi_clk_o = 1'b0;
    spi_csn_o = 1'b0;
    spi_mosi_o = 1'b0;
    #20 spi_csn_o = 1'b1;
  end
  // The 7 ns lead keeps link edges clear of system clock edges when called on a clock edge
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
                      output logic [7:0] st, output logic [7:0] rd);
    logic [15:0] sh_out; // Bits to send
    logic [15:0] sh_in;  // Bits seen on the rising edge
    sh_out = {cmd, dat};
    #7 spi_csn_o = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      spi_mosi_o = sh_out[k];
      #40 spi_clk_o = 1'b1;
      sh_in[k] = spi_miso_i;
      #40 spi_clk_o = 1'b0;
    end
    #40 spi_csn_o = 1'b1;
    // Released line shows the inverse, so a stale bit cannot pass
    spi_mosi_o = ~sh_out[0];
    #200;
    st = sh_in[15:8];
    rd = sh_in[7:0];
  endtask : xfer
endmodule : rcb_host_model

// file: tb/testbench.sv
// Self-checking bench: register frames through the host model, event pulses.
// Assumes the register bank top and its package are compiled first.
`timescale 1ns/1ps
module testbench;
  import rcb_pkg::*;
  logic       sys_clk_i, rst_n_i;            // Clock and reset
  logic       spi_clk, spi_csn, spi_mosi;    // Host side of the link
  logic       spi_miso, irq_n;               // Device answers
  logic [2:0] ev;                            // Events: 0 retry, 1 tx, 2 rx
  logic       crc_en, crc_len, pwr, role;    // Control outputs
  logic [5:0] ack, pipes;                    // Pipe enables
  logic [1:0] aw;                            // Address width
  logic [7:0] st, rv;                        // Status and read bytes
  int         errors, comparisons;           // Verdict counters
  logic [4:0] ta [0:6] = '{5'h00, 5'h00, 5'h01, 5'h00, 5'h01, 5'h02, 5'h03};
  logic [7:0] td [0:6] = '{8'h7f, 8'h07, 8'h00, 8'h06, 8'h21, 8'h3c, 8'h02};
  logic [7:0] tx [0:6] = '{8'h7f, 8'h0f, 8'h00, 8'h06, 8'h21, 8'h3c, 8'h02};
  logic [7:0] rsv [0:3] = '{8'h80, 8'h40, 8'h80, 8'h04}; // One reserved bit each
  logic [7:0] def [0:3] = '{8'h08, 8'h3f, 8'h03, 8'h03}; // Defaults
  initial sys_clk_i = 1'b0;
  always #5 sys_clk_i = ~sys_clk_i;
  rcb_host_model host (.spi_clk_o(spi_clk), .spi_csn_o(spi_csn), .spi_mosi_o(spi_mosi),
    .spi_miso_i(spi_miso));
  rcb_core uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .spi_clk_i(spi_clk),
    .spi_csn_i(spi_csn), .spi_mosi_i(spi_mosi), .spi_miso_o(spi_miso),
    .rx_ready_event_i(ev[2]), .tx_sent_event_i(ev[1]), .retry_limit_event_i(ev[0]),
    .irq_n_o(irq_n), .crc_enable_o(crc_en), .crc_length_select_o(crc_len),
    .power_up_bit_o(pwr), .primary_role_select_o(role), .auto_ack_enable_o(ack),
    .rx_pipe_enable_o(pipes), .address_width_field_o(aw));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host.xfer({RCB_CMD_WRITE, a}, d, st, rv);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    host.xfer({RCB_CMD_READ, a}, 8'h00, st, rv);
    check(rv, exp);
  endtask : rd
  task automatic outs(input logic [7:0] c, input logic [7:0] a, input logic [7:0] p);
    check({4'h0, crc_en, crc_len, pwr, role}, c);
    check({2'b00, ack}, a);
    check({2'b00, pipes}, p);
  endtask : outs
  // One-clock event pulse; the pin settles on the next edge
  task automatic pulse(input int k);
    @(posedge sys_clk_i);
    ev <= 3'b001 << k;
    @(posedge sys_clk_i);
    ev <= 3'b000;
    repeat (2) @(posedge sys_clk_i);
  endtask : pulse
  task automatic print_verdict();
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // A hang cannot outlast forty-four frames by this much
  initial begin
    #500000;
    errors++;
    print_verdict();
  end
  initial begin
    errors = 0;
    comparisons = 0;
    ev = 3'b000;
    rst_n_i = 1'b0;
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (int k = 0; k < 4; k++) rd(5'(k), def[k]);
    check(st, RCB_RST_STATUS);
    for (int k = 0; k < 7; k++) begin
      wr(ta[k], td[k]);
      rd(ta[k], tx[k]);
    end
    outs(8'h0e, 8'h21, 8'h3c);
    check({6'h00, aw}, {6'h00, RCB_AW_FOUR});
    wr(RCB_OFS_AUTO_ACK, 8'h00);
    check({7'h00, crc_en}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(5'(k), rsv[k]);
      rd(5'(k), def[k]);
    end
    outs(8'h08, 8'h3f, 8'h03);
    rd(5'h05, 8'h00);
    rd(RCB_OFS_TEST_LO, 8'h00);
    for (int k = 0; k < 3; k++) begin
      pulse(k);
      check({7'h00, irq_n}, 8'h00);
      rd(RCB_OFS_STATUS, RCB_RST_STATUS | (8'h10 << k));
      wr(RCB_OFS_STATUS, 8'h10 << k);
      check({7'h00, irq_n}, 8'h01);
      wr(RCB_OFS_CONTROL, 8'h08 | (8'h10 << k));
      pulse(k);
      check({7'h00, irq_n}, 8'h01);
      wr(RCB_OFS_STATUS, 8'h10 << k);
      wr(RCB_OFS_CONTROL, 8'h08);
    end
    print_verdict();
  end
endmodule : testbench
